// ### design/gpio_ports_abc.sv
// Three general purpose ports, pull-ups on the second port, change detect and pin sharing
//
// Function
// RULE1: Direction one tristates pin, zero drives latch
// RULE2: Second port eight bits, own direction register
// RULE3: Third port eight bits, same direction encoding
// RULE4: Option bit 7 low enables port pull-ups
// RULE5: Output pins never get a pull-up
// RULE6: Pull-ups off after reset, option all ones
// RULE7: Only upper four input pins detect change
// RULE8: Mismatch with read snapshot sets change flag
// RULE9: Mismatch keeps setting; port access ends it
// RULE10: Change flag can wake from sleep
// RULE11: Software avoids polling second port meanwhile
// RULE12: Second-port bit 0 external interrupt, edge selectable
// RULE13: Programming mode uses bits 6 and 7
// RULE14: Enabled peripheral overrides third-port direction bit
// RULE15: Software avoids bit ops on third direction
// RULE16: Select picks peripheral data and its enable
// RULE17: First-port bit 4 timer clock, open drain
// RULE18: First-port bit 5 is serial slave select
// RULE19: Software sets converter code for slave select
// RULE20: Third-port bits 3 and 4 carry serial lines
// RULE21: Unimplemented register bits read as zero
// RULE22: Port read gives pins, write sets latch
// RULE23: First port six bits, same direction encoding
// RULE24: Analogue first-port pins read zero after reset
// RULE25: Mismatch checked each clock, flag held
`timescale 1ns/1ps
module gpio_ports_abc (
    input wire logic clk,
    input wire logic rst_n,
    input wire gpio_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    input wire logic [5:0] pa_in,
    output logic [5:0] pa_out,
    output logic [5:0] pa_oe_n,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    output logic [7:0] pb_pullup_en,
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe_n,
    input wire gpio_pkg::periph_ctl_t pc_periph,
    input wire logic prog_mode,
    input wire logic prog_data_drive,
    input wire logic prog_data_val,
    output logic prog_clk,
    output logic prog_data,
    output logic timer_ext_clock_in,
    output logic serial_select_n,
    output logic serial_clk_in,
    output logic serial_data_in,
    output logic port_change_flag,
    output logic ext_irq_flag,
    output logic wake_req
);
    import gpio_pkg::*;

    logic [5:0] latch_a_q, latch_a_d;
    logic [7:0] latch_b_q, latch_b_d;
    logic [7:0] latch_c_q, latch_c_d;
    logic [5:0] dir_a_q, dir_a_d;
    logic [7:0] dir_b_q, dir_b_d;
    logic [7:0] dir_c_q, dir_c_d;
    logic [7:0] option_q, option_d;
    logic [2:0] ancfg_q, ancfg_d;
    logic [3:0] snap_q, snap_d;
    logic chg_q, chg_d;
    logic ext_q, ext_d;
    logic ext_pin_q;
    logic [7:0] rdata_q, rdata_d;
    logic [5:0] taps_q, taps_d;

    // Register decode
    wire wr = reg_req.wr;
    wire rd = reg_req.rd;
    wire [7:0] wd = reg_req.wdata;
    wire hit_pa = reg_req.addr == ADDR_PA;
    wire hit_pb = reg_req.addr == ADDR_PB;
    wire hit_pc = reg_req.addr == ADDR_PC;
    wire hit_intc = reg_req.addr == ADDR_INTC;
    wire hit_opt = reg_req.addr == ADDR_OPT;
    wire hit_dira = reg_req.addr == ADDR_DIRA;
    wire hit_dirb = reg_req.addr == ADDR_DIRB;
    wire hit_dirc = reg_req.addr == ADDR_DIRC;
    wire hit_ancfg = reg_req.addr == ADDR_ANCFG;
    wire pb_access = (wr | rd) & hit_pb;

    // Next values of software registers; port writes only touch latches
    assign latch_a_d = (wr & hit_pa) ? wd[5:0] : latch_a_q; // [RULE22] [RULE23]
    assign latch_b_d = (wr & hit_pb) ? wd : latch_b_q; // [RULE22]
    assign latch_c_d = (wr & hit_pc) ? wd : latch_c_q; // [RULE22]
    assign dir_a_d = (wr & hit_dira) ? wd[5:0] : dir_a_q; // [RULE23]
    assign dir_b_d = (wr & hit_dirb) ? wd : dir_b_q; // [RULE2]
    assign dir_c_d = (wr & hit_dirc) ? wd : dir_c_q; // [RULE3]
    assign option_d = (wr & hit_opt) ? wd : option_q;
    assign ancfg_d = (wr & hit_ancfg) ? wd[2:0] : ancfg_q;

    // First port: analogue pins read zero, timer pin is open drain
    wire [5:0] ana_mask = analog_mask(ancfg_q);
    wire [5:0] pa_level = pa_in & ~ana_mask; // [RULE24]
    wire [5:0] od_mask = 6'h01 << PA_TIMER_BIT;
    assign pa_out = latch_a_q & ~od_mask; // [RULE17]
    // Open drain only pulls low, a latch one releases the pin
    assign pa_oe_n = dir_a_q | (latch_a_q & od_mask); // [RULE1] [RULE17] [RULE23]

    // Second port: programming mode owns bits 6 and 7
    wire [7:0] pclk_mask = 8'h01 << PB_PCLK_BIT;
    wire [7:0] pdat_mask = 8'h01 << PB_PDATA_BIT;
    wire [7:0] prog_in_mask = prog_mode ? (pclk_mask | pdat_mask) : 8'h00; // [RULE13]
    wire [7:0] prog_drv_mask = (prog_mode & prog_data_drive) ? pdat_mask : 8'h00; // [RULE13]
    wire [7:0] dir_b_eff = (dir_b_q | prog_in_mask) & ~prog_drv_mask;
    wire [7:0] prog_val = prog_data_val ? pdat_mask : 8'h00;
    assign pb_out = (latch_b_q & ~prog_drv_mask) | (prog_val & prog_drv_mask);
    assign pb_oe_n = dir_b_eff; // [RULE1] [RULE2]
    // Pull-ups follow the global enable but only on inputs
    wire pullup_on = ~option_q[OPT_PULLUP_N_BIT]; // [RULE4] [RULE6]
    assign pb_pullup_en = pullup_on ? dir_b_eff : 8'h00; // [RULE4] [RULE5]

    // Third port: an enabled peripheral takes the pin, data and enable
    wire [7:0] psel = pc_periph.sel;
    wire [7:0] dir_c_eff = (dir_c_q & ~psel) | (~pc_periph.drive & psel); // [RULE14]
    assign pc_out = (latch_c_q & ~psel) | (pc_periph.dout & psel); // [RULE16]
    assign pc_oe_n = dir_c_eff; // [RULE3] [RULE16]

    // Change detection on input pins of the upper nibble
    wire [3:0] chg_inputs = dir_b_q[7:4]; // [RULE7]
    wire [3:0] mism_bits = (pb_in[7:4] ^ snap_q) & chg_inputs; // [RULE7] [RULE8]
    wire mismatch = |mism_bits; // [RULE8] [RULE25]
    // Any access re-latches, so polling would hide changes
    assign snap_d = pb_access ? pb_in[7:4] : snap_q; // [RULE9]
    wire chg_wr = wr & hit_intc;
    // Mismatch sets every cycle and wins over a software clear
    assign chg_d = mismatch | (chg_wr ? wd[INTC_CHANGE_BIT] : chg_q); // [RULE9] [RULE25]

    // External interrupt edge on bit 0
    wire ext_pin = pb_in[PB_EXT_BIT];
    wire rise_sel = option_q[OPT_EDGE_BIT];
    wire ext_edge = rise_sel ? (ext_pin & ~ext_pin_q) : (~ext_pin & ext_pin_q); // [RULE12]
    assign ext_d = ext_edge | (chg_wr ? wd[INTC_EXT_BIT] : ext_q); // [RULE12]

    // Read mux, unimplemented bits and unmapped offsets read zero
    wire [7:0] intc_val = {6'h00, ext_q, chg_q};
    assign rdata_d = !rd ? 8'h00 :
        hit_pa ? {2'h0, pa_level} : // [RULE21] [RULE22]
        hit_pb ? pb_in : // [RULE22]
        hit_pc ? pc_in : // [RULE22]
        hit_intc ? intc_val :
        hit_opt ? option_q :
        hit_dira ? {2'h0, dir_a_q} : // [RULE21]
        hit_dirb ? dir_b_q :
        hit_dirc ? dir_c_q :
        hit_ancfg ? {5'h00, ancfg_q} : 8'h00; // [RULE21]

    // Pin taps for the sharing peripherals, registered as data
    assign taps_d = {pa_in[PA_TIMER_BIT], // [RULE17]
        pa_in[PA_SELECT_BIT], // [RULE18]
        prog_mode & pb_in[PB_PCLK_BIT], // [RULE13]
        prog_mode & pb_in[PB_PDATA_BIT], // [RULE13]
        pc_in[PC_SCLK_BIT], // [RULE20]
        pc_in[PC_SDATA_BIT]}; // [RULE20]

    // Software registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_a_q <= RST_LATCH_A;
            latch_b_q <= RST_LATCH8;
            latch_c_q <= RST_LATCH8;
            dir_a_q <= RST_DIRA;
            dir_b_q <= RST_DIR8;
            dir_c_q <= RST_DIR8;
            option_q <= RST_OPT; // [RULE6]
            ancfg_q <= RST_ANCFG; // [RULE24]
        end else begin
            latch_a_q <= latch_a_d;
            latch_b_q <= latch_b_d;
            latch_c_q <= latch_c_d;
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
            option_q <= option_d;
            ancfg_q <= ancfg_d;
        end
    end

    // Event state and read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Pins become the reference, so no false change or edge follows reset
            snap_q <= pb_in[7:4];
            chg_q <= 1'b0;
            ext_q <= 1'b0;
            ext_pin_q <= ext_pin;
            rdata_q <= 8'h00;
            taps_q <= 6'h00;
        end else begin
            snap_q <= snap_d;
            chg_q <= chg_d;
            ext_q <= ext_d;
            ext_pin_q <= ext_pin;
            rdata_q <= rdata_d;
            taps_q <= taps_d;
        end
    end

    // Outputs
    assign rdata = rdata_q;
    assign port_change_flag = chg_q;
    assign ext_irq_flag = ext_q;
    // Flag is level, so wake holds while the flag stays set
    assign wake_req = chg_q; // [RULE10]
    assign timer_ext_clock_in = taps_q[5];
    assign serial_select_n = taps_q[4];
    assign prog_clk = taps_q[3];
    assign prog_data = taps_q[2];
    assign serial_clk_in = taps_q[1];
    assign serial_data_in = taps_q[0];

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_dir_b_drive: assert property ( // [RULE1]
        (wr && hit_dirb && !prog_mode) ##1 !prog_mode |-> pb_oe_n == $past(wd))
        else $error("second port enable does not follow direction write");

    a_dir_c_drive: assert property ( // [RULE3]
        (wr && hit_dirc) ##1 (psel == 8'h00) |-> pc_oe_n == $past(wd)
            && pc_out == latch_c_q)
        else $error("third port direction or latch not on pins");

    a_pullup_global: assert property ( // [RULE4]
        (wr && hit_opt && !wd[OPT_PULLUP_N_BIT]) ##1 !prog_mode
            |-> pb_pullup_en == dir_b_q)
        else $error("pull-ups not enabled on inputs after clear");

    a_pullup_output: assert property ( // [RULE5]
        (pb_pullup_en & ~pb_oe_n) == 8'h00)
        else $error("pull-up active on a driven pin");

    a_reset_state: assert property ( // [RULE6]
        $rose(rst_n) |-> option_q == RST_OPT && pb_pullup_en == 8'h00
            && port_change_flag == 1'b0)
        else $error("option or pull-ups wrong after reset");

    a_change_masked: assert property ( // [RULE7]
        (dir_b_q[7:4] == 4'h0) |-> !mismatch)
        else $error("output pin took part in change detect");

    a_change_sets: assert property ( // [RULE8]
        mismatch |=> port_change_flag)
        else $error("mismatch did not set the change flag");

    a_clear_held: assert property ( // [RULE9]
        (chg_wr && !wd[INTC_CHANGE_BIT] && mismatch) |=> port_change_flag)
        else $error("clear won over a standing mismatch");

    a_read_ends: assert property ( // [RULE9]
        (rd && hit_pb) ##1 ($stable(pb_in) && $stable(dir_b_q)) |-> !mismatch)
        else $error("port read did not end the mismatch");

    a_flag_holds: assert property ( // [RULE25]
        (port_change_flag && !chg_wr) |=> port_change_flag)
        else $error("change flag dropped without a clear");

    a_wake_follows: assert property ( // [RULE10]
        $rose(port_change_flag) |-> wake_req)
        else $error("change flag raised without wake");

    a_ext_edge: assert property ( // [RULE12]
        (rise_sel && $rose(ext_pin)) |=> ext_irq_flag)
        else $error("selected edge missed on external pin");

    a_override: assert property ( // [RULE14]
        (psel[PC_SCLK_BIT] && pc_periph.drive[PC_SCLK_BIT])
            |-> !pc_oe_n[PC_SCLK_BIT] && pc_out[PC_SCLK_BIT] == pc_periph.dout[PC_SCLK_BIT])
        else $error("peripheral did not take its pin");

    a_open_drain: assert property ( // [RULE17]
        (wr && hit_pa && wd[PA_TIMER_BIT]) |=> pa_oe_n[PA_TIMER_BIT]
            && !pa_out[PA_TIMER_BIT])
        else $error("open drain pin driven high");

    a_slave_tap: assert property ( // [RULE18]
        $past(rst_n) |-> serial_select_n == $past(pa_in[PA_SELECT_BIT]))
        else $error("slave select tap lags wrongly");

    a_analog_zero: assert property ( // [RULE24]
        (rd && hit_pa && ancfg_q == RST_ANCFG) |=> (rdata[5:0] & ANA_ALL) == 6'h00
            && rdata[4] == $past(pa_in[PA_TIMER_BIT]) && rdata[7:6] == 2'h0)
        else $error("analogue pin read nonzero");

    a_high_zero: assert property ( // [RULE21]
        (rd && (hit_pa || hit_dira)) |=> rdata[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");

    // Register view, pin drive and tap timing
    a_dir_a_drive: assert property ( // [RULE23]
        (wr && hit_dira) |=> (pa_oe_n & ~od_mask) == ($past(wd[5:0]) & ~od_mask))
        else $error("first port enable does not follow direction write");

    a_latch_a_out: assert property ( // [RULE22]
        (wr && hit_pa) |=> (pa_out & ~od_mask) == ($past(wd[5:0]) & ~od_mask))
        else $error("first port latch not on its outputs");

    a_latch_b_out: assert property ( // [RULE1]
        (wr && hit_pb && !prog_mode) ##1 !prog_mode |-> pb_out == $past(wd))
        else $error("second port latch not on its outputs");

    a_latch_c_out: assert property ( // [RULE3]
        (wr && hit_pc) ##1 (psel == 8'h00) |-> pc_out == $past(wd))
        else $error("third port latch not on its outputs");

    a_pullup_off: assert property ( // [RULE4]
        option_q[OPT_PULLUP_N_BIT] |-> pb_pullup_en == 8'h00)
        else $error("pull-up on while global control is high");

    a_pb_read: assert property ( // [RULE22]
        (rd && hit_pb) |=> rdata == $past(pb_in))
        else $error("second port read is not the pin levels");

    a_pc_read: assert property ( // [RULE22]
        (rd && hit_pc) |=> rdata == $past(pc_in))
        else $error("third port read is not the pin levels");

    a_idle_rdata: assert property ( // [RULE21]
        !rd |=> rdata == 8'h00)
        else $error("read data nonzero without a read");

    a_opt_read: assert property ( // [RULE6]
        (rd && hit_opt) |=> rdata == $past(option_q))
        else $error("option read does not match register");

    a_ancfg_high: assert property ( // [RULE21]
        (rd && hit_ancfg) |=> rdata[7:3] == 5'h00)
        else $error("converter config upper bits read nonzero");

    a_ext_fall: assert property ( // [RULE12]
        (!rise_sel && $fell(ext_pin)) |=> ext_irq_flag)
        else $error("falling edge missed on external pin");

    a_prog_taps: assert property ( // [RULE13]
        !$past(prog_mode) |-> !prog_clk && !prog_data)
        else $error("programming taps active outside programming mode");

    a_prog_drive: assert property ( // [RULE13]
        (prog_mode && prog_data_drive)
            |-> !pb_oe_n[PB_PDATA_BIT] && pb_out[PB_PDATA_BIT] == prog_data_val)
        else $error("programming data not driven");

    a_sclk_tap: assert property ( // [RULE20]
        $past(rst_n) |-> serial_clk_in == $past(pc_in[PC_SCLK_BIT]))
        else $error("serial clock tap lags wrongly");

    a_sdata_tap: assert property ( // [RULE20]
        $past(rst_n) |-> serial_data_in == $past(pc_in[PC_SDATA_BIT]))
        else $error("serial data tap lags wrongly");

    a_timer_tap: assert property ( // [RULE17]
        $past(rst_n) |-> timer_ext_clock_in == $past(pa_in[PA_TIMER_BIT]))
        else $error("timer clock tap lags wrongly");

    a_periph_dir: assert property ( // [RULE14]
        (pc_oe_n & psel) == (~pc_periph.drive & psel))
        else $error("peripheral direction not forced");

    c_change_flag: cover property ($rose(port_change_flag));
    c_ext_flag: cover property ($rose(ext_irq_flag));
    c_read_clear: cover property (port_change_flag ##1 (rd && hit_pb)
        ##1 (chg_wr && !wd[INTC_CHANGE_BIT]) ##1 !port_change_flag);
    c_override: cover property (psel != 8'h00 && dir_c_q != dir_c_eff);
    c_prog_drive: cover property (prog_mode && prog_data_drive);
endmodule : gpio_ports_abc

// ### shared/gpio_pkg.sv
// Register map, field positions, reset values and carrier types for the port block
package gpio_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_PA = 8'h05;
    localparam logic [7:0] ADDR_PB = 8'h06;
    localparam logic [7:0] ADDR_PC = 8'h07;
    localparam logic [7:0] ADDR_INTC = 8'h0b;
    localparam logic [7:0] ADDR_OPT = 8'h81;
    localparam logic [7:0] ADDR_DIRA = 8'h85;
    localparam logic [7:0] ADDR_DIRB = 8'h86;
    localparam logic [7:0] ADDR_DIRC = 8'h87;
    localparam logic [7:0] ADDR_ANCFG = 8'h9f;
    // Reset values
    localparam logic [7:0] RST_OPT = 8'hff;
    localparam logic [5:0] RST_DIRA = 6'h3f;
    localparam logic [7:0] RST_DIR8 = 8'hff;
    localparam logic [5:0] RST_LATCH_A = 6'h00;
    localparam logic [7:0] RST_LATCH8 = 8'h00;
    localparam logic [2:0] RST_ANCFG = 3'h0;
    // Field positions
    localparam int OPT_PULLUP_N_BIT = 7;
    localparam int OPT_EDGE_BIT = 6;
    localparam int INTC_CHANGE_BIT = 0;
    localparam int INTC_EXT_BIT = 1;
    localparam int PA_TIMER_BIT = 4;
    localparam int PA_SELECT_BIT = 5;
    localparam int PB_EXT_BIT = 0;
    localparam int PB_PCLK_BIT = 6;
    localparam int PB_PDATA_BIT = 7;
    localparam int PC_SCLK_BIT = 3;
    localparam int PC_SDATA_BIT = 4;
    // Analogue pin masks on the first port
    localparam logic [5:0] ANA_ALL = 6'h2f;
    localparam logic [5:0] ANA_PART = 6'h0b;
    localparam logic [5:0] ANA_NONE = 6'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Peripheral claim of third-port pins, one bit per pin
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dout;
        logic [7:0] drive;
    } periph_ctl_t;

    // Analogue pins of the first port for a configuration code
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        case (cfg)
            3'h4, 3'h5: analog_mask = ANA_PART;
            3'h6, 3'h7: analog_mask = ANA_NONE;
            default: analog_mask = ANA_ALL;
        endcase
    endfunction : analog_mask
endpackage : gpio_pkg

// ### verification/pin_board.sv
// Board model: pin drivers, weak pull-ups and external sources
`timescale 1ns/1ps
module pin_board #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic [W-1:0] drv_val,
    input wire logic [W-1:0] drv_oe_n,
    input wire logic [W-1:0] pullup_en,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin
);
    logic [W-1:0] float_q = '0;

    // A floating line wanders, so a stale level is never trusted
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end

    // Device driver wins, then the external source, then the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!drv_oe_n[i]) begin
                pin[i] = drv_val[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule : pin_board

// ### verification/tb.sv
// Self-checking bench for the three-port block
`timescale 1ns/1ps
module tb;
    import gpio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req = '0;
    periph_ctl_t per = '0;
    logic pmode = 1'b0, pdrv = 1'b0, pval = 1'b0, rd_pend = 1'b0;
    logic [7:0] rdata, pb_out, pb_oe_n, pb_pu, pc_out, pc_oe_n, pb_pin, pc_pin;
    logic [5:0] pa_out, pa_oe_n, pa_pin, ena = 6'h3f;
    logic [7:0] ea = '0, eb = '0, ec = '0, enb = 8'hff, enc = 8'hff, lat, d;
    logic pclk, pdat, tclk, ssel_n, sclk, sdat, chg, exti, wake;
    logic [7:0] qexp[$];
    int err_total = 0, tests_run = 0, seed = 10769;

    gpio_ports_abc u_gpio_ports_abc (.clk(clk), .rst_n(rst_n), .reg_req(req), .rdata(rdata),
        .pa_in(pa_pin), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_pin), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pu), .pc_in(pc_pin), .pc_out(pc_out),
        .pc_oe_n(pc_oe_n), .pc_periph(per), .prog_mode(pmode), .prog_data_drive(pdrv),
        .prog_data_val(pval), .prog_clk(pclk), .prog_data(pdat), .timer_ext_clock_in(tclk),
        .serial_select_n(ssel_n), .serial_clk_in(sclk), .serial_data_in(sdat),
        .port_change_flag(chg), .ext_irq_flag(exti), .wake_req(wake));
    pin_board #(.W(6)) u_pin_board_a (.clk(clk), .drv_val(pa_out), .drv_oe_n(pa_oe_n),
        .pullup_en(6'h00), .ext_val(ea[5:0]), .ext_en(ena), .pin(pa_pin));
    pin_board #(.W(8)) u_pin_board_b (.clk(clk), .drv_val(pb_out), .drv_oe_n(pb_oe_n),
        .pullup_en(pb_pu), .ext_val(eb), .ext_en(enb), .pin(pb_pin));
    pin_board #(.W(8)) u_pin_board_c (.clk(clk), .drv_val(pc_out), .drv_oe_n(pc_oe_n),
        .pullup_en(8'h00), .ext_val(ec), .ext_en(enc), .pin(pc_pin));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bus tasks leave the strobe up; idle releases it and settles at negedge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        qexp.push_back(e);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            req <= '0;
        end
        @(negedge clk);
    endtask : idle

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // Read data stand one cycle after the strobe; oldest note is compared
    always @(posedge clk) begin
        if (rd_pend) begin
            chk("rdata", qexp.size() > 0 ? qexp.pop_front() : 8'hxx, rdata);
        end
        rd_pend <= req.rd;
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        {ea, eb, ec} = 24'($random(seed));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        idle(1);
        chk("pullups", 8'h00, pb_pu);
        chk("pb oe_n", 8'hff, pb_oe_n);
        chk("change", 8'h00, {7'h0, chg});
        chk("ext flag", 8'h00, {7'h0, exti});
        rd(ADDR_OPT, RST_OPT);
        rd(ADDR_DIRA, {2'b00, RST_DIRA});
        rd(ADDR_DIRB, RST_DIR8);
        rd(ADDR_DIRC, RST_DIR8);
        rd(ADDR_PA, {2'b00, ea[5:0] & 6'h10});
        rd(8'h40, 8'h00);
        // Second port drive, pull-ups only on inputs
        lat = 8'($random(seed));
        wr(ADDR_DIRB, 8'h0f);
        wr(ADDR_PB, lat);
        wr(ADDR_OPT, 8'h7f);
        idle(1);
        @(posedge clk);
        enb <= 8'h00;
        idle(1);
        chk("pb oe_n", 8'h0f, pb_oe_n);
        chk("pb out", lat & 8'hf0, pb_out & 8'hf0);
        chk("pullups", 8'h0f, pb_pu);
        rd(ADDR_PB, {lat[7:4], 4'hf});
        wr(ADDR_OPT, 8'hff);
        idle(2);
        chk("pullups", 8'h00, pb_pu);
        // First port: open drain bit 4, analogue codes
        @(posedge clk);
        enb <= 8'hff;
        wr(ADDR_ANCFG, 8'h06);
        wr(ADDR_DIRA, 8'h00);
        wr(ADDR_PA, 8'h10);
        idle(2);
        chk("pa oe_n", 8'h10, {2'b00, pa_oe_n});
        chk("pa out", 8'h00, {4'h0, pa_out[3:0]});
        wr(ADDR_PA, 8'h2f);
        ena <= 6'h00;
        idle(2);
        chk("pa oe_n", 8'h00, {2'b00, pa_oe_n});
        rd(ADDR_PA, 8'h2f);
        ena <= 6'h3f;
        wr(ADDR_DIRA, 8'hff);
        rd(ADDR_DIRA, 8'h3f);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_ANCFG, 8'(k));
            rd(ADDR_PA, {2'b00, ea[5:0] & ~(k < 4 ? 6'h2f : k < 6 ? 6'h0b : 6'h00)});
        end
        idle(3);
        chk("timer clk", {7'h0, ea[4]}, {7'h0, tclk});
        chk("select", {7'h0, ea[5]}, {7'h0, ssel_n});
        // Third port; direction is not touched while a peripheral holds pins
        lat = 8'($random(seed));
        d = 8'($random(seed));
        wr(ADDR_DIRC, 8'h0f);
        wr(ADDR_PC, lat);
        idle(2);
        chk("pc oe_n", 8'h0f, pc_oe_n);
        @(posedge clk);
        per <= '{sel: 8'h18, dout: d, drive: 8'h08};
        enc <= 8'hf7;
        idle(3);
        chk("pc oe_n", 8'h17, pc_oe_n);
        chk("pc out", ((lat & 8'he7) | (d & 8'h18)) & 8'he8, pc_out & 8'he8);
        chk("sclk", {7'h0, d[3]}, {7'h0, sclk});
        chk("sdata", {7'h0, ec[4]}, {7'h0, sdat});
        @(posedge clk);
        per <= '{sel: 8'h00, dout: d, drive: 8'hff};
        enc <= 8'hff;
        idle(2);
        chk("pc oe_n", 8'h0f, pc_oe_n);
        // Change detect: low pins and output pins never count
        wr(ADDR_DIRB, 8'hff);
        rd(ADDR_PB, eb);
        wr(ADDR_INTC, 8'h00);
        idle(1);
        @(posedge clk);
        eb <= eb ^ 8'h0f;
        idle(3);
        chk("change", 8'h00, {7'h0, chg});
        wr(ADDR_PB, ~eb);
        wr(ADDR_DIRB, 8'h7f);
        wr(ADDR_INTC, 8'h00);
        idle(3);
        chk("change", 8'h00, {7'h0, chg});
        wr(ADDR_DIRB, 8'hff);
        idle(1);
        @(posedge clk);
        eb <= eb ^ 8'h20;
        idle(3);
        chk("change", 8'h01, {7'h0, chg});
        chk("wake", 8'h01, {7'h0, wake});
        wr(ADDR_INTC, 8'h00);
        idle(3);
        chk("change", 8'h01, {7'h0, chg});
        rd(ADDR_PB, eb);
        wr(ADDR_INTC, 8'h00);
        idle(2);
        chk("change", 8'h00, {7'h0, chg});
        // External interrupt, both edge selections, both edges
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            eb[0] <= ~k[0];
            idle(2);
            wr(ADDR_OPT, {1'b1, k[1], 6'h3f});
            wr(ADDR_INTC, 8'h00);
            idle(1);
            @(posedge clk);
            eb[0] <= k[0];
            idle(3);
            chk("ext flag", {7'h0, k[1] == k[0]}, {7'h0, exti});
        end
        // Programming mode turns bits 6 and 7 around
        wr(ADDR_DIRB, 8'h00);
        idle(1);
        @(posedge clk);
        pmode <= 1'b1;
        eb <= 8'($random(seed));
        idle(3);
        chk("prog clk", {7'h0, eb[6]}, {7'h0, pclk});
        chk("prog data", {7'h0, eb[7]}, {7'h0, pdat});
        chk("prog oe_n", 8'hc0, pb_oe_n & 8'hc0);
        @(posedge clk);
        pdrv <= 1'b1;
        pval <= 1'b1;
        idle(2);
        chk("prog drive", 8'h40, {pb_oe_n[7], pb_out[7], 6'h00});
        @(posedge clk);
        pmode <= 1'b0;
        pdrv <= 1'b0;
        idle(3);
        chk("prog clk", 8'h00, {7'h0, pclk});
        idle(2);
        wrap_up();
    end
endmodule : tb
